// *** uim_regs.svh ***
// Constants for the underimpedance protection block
`ifndef UIM_REGS_SVH
`define UIM_REGS_SVH
`define UIM_Z_W 16
`define UIM_RATIO_W 16
`define UIM_T_W 20
`define UIM_CNT_W 16
`define UIM_TS_W 48
`define UIM_LOG_DEPTH 12
`define UIM_LOG_AW 4
`define UIM_LOG_LAST 4'hb
`define UIM_THR_DEFAULT 16'h03e8
`define UIM_HYST_NUM 8'h67
`define UIM_HYST_DEN 8'h64
`define UIM_RATIO_SCALE 16'h0064
`define UIM_RATIO_MAX 20'h1e848
`define UIM_T_MAX 20'h5dc00
`define UIM_HIST_20MS 6'h04
`define UIM_HIST_200MS 6'h28
`define UIM_HIST_LEN 6'h29
`define UIM_SG_MAX 3'h7
`endif

// *** uim_pkg.sv ***
// Types shared by the underimpedance protection block
package uim_pkg;
  typedef enum logic [2:0] {
    UIM_OPM_PE = 3'h1,
    UIM_OPM_PP = 3'h2,
    UIM_OPM_PS = 3'h4
  } uim_opmode_t;
  typedef enum logic [4:0] {
    UIM_NODE_ON = 5'h01,
    UIM_NODE_BLOCKED = 5'h02,
    UIM_NODE_TEST = 5'h04,
    UIM_NODE_TEST_BLK = 5'h08,
    UIM_NODE_OFF = 5'h10
  } uim_node_t;
  typedef enum logic [3:0] {
    UIM_ST_NORMAL = 4'h1,
    UIM_ST_START = 4'h2,
    UIM_ST_TRIP = 4'h4,
    UIM_ST_BLOCKED = 4'h8
  } uim_state_t;
  typedef struct packed {
    logic [15:0] il1;
    logic [15:0] il2;
    logic [15:0] il3;
    logic [15:0] u1;
    logic [15:0] u2;
    logic [15:0] u3;
    logic [15:0] u4;
  } uim_meas_t;
  typedef struct packed {
    logic [1:0] stage;
    logic [1:0] kind;
    logic on;
  } uim_event_t;
  typedef struct packed {
    logic [47:0] stamp;
    uim_event_t evt;
    logic [2:0] loop;
    logic [15:0] z_pre20;
    logic [15:0] z_now;
    logic [15:0] z_pre200;
    logic [19:0] t_remain;
    logic [2:0] group;
  } uim_record_t;
  typedef struct packed {
    logic [15:0] starts;
    logic [15:0] trips;
    logic [15:0] blocks;
  } uim_counts_t;
endpackage

// *** uim_log_mem.sv ***
// Twelve-entry record memory with registered read port
`timescale 1ns/1ps
`include "uim_regs.svh"
module uim_log_mem
  import uim_pkg::*;
(
  // Clock
  input wire logic clock,
  // Write port
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire uim_record_t wr_data,
  // Read port
  input wire logic [3:0] rd_addr,
  output uim_record_t rd_data
);
  uim_record_t mem [`UIM_LOG_DEPTH];
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// *** uim_protection.sv ***
// Underimpedance protection: two stages, events, counters and fault log
`timescale 1ns/1ps
`include "uim_regs.svh"
module uim_protection
  import uim_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Measurement, one program cycle per strobe
  input wire logic cycle_tick,
  input wire uim_meas_t meas,
  input wire logic [47:0] time_stamp,
  // Settings, shared or per stage index
  input wire uim_opmode_t op_mode,
  input wire logic node_mode_allowed,
  input wire uim_node_t node_operating_mode,
  input wire logic forcing_enabled,
  input wire uim_state_t force_status [2],
  input wire logic [15:0] impedance_pickup_threshold [2],
  input wire logic [19:0] fixed_delay_characteristic [2],
  input wire logic [2:0] setting_group,
  input wire logic [1:0] evt_on_sel,
  input wire logic [1:0] evt_off_sel,
  // Blocking matrix
  input wire logic [1:0] block_in,
  // Outputs, with the counter clear and log read address inputs
  output logic [1:0] start_out,
  output logic [1:0] trip_out,
  output logic [1:0] blocked_out,
  output uim_state_t condition [2],
  output uim_node_t node_behaviour,
  output logic [15:0] ratio_out [2],
  output logic [19:0] expected_time [2],
  output logic [19:0] remaining_time [2],
  output logic event_valid,
  output uim_event_t event_data,
  output logic [47:0] event_stamp,
  output uim_counts_t counts [2],
  input wire logic counts_clear,
  input wire logic [3:0] log_rd_addr,
  output uim_record_t log_rd_data,
  output logic [3:0] log_wr_ptr
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    uim_state_t [1:0] st;
    logic [1:0] pick;
    logic [1:0] blk;
    logic [1:0][19:0] tmr;
    logic [1:0][15:0] ratio;
    logic [1:0][2:0] loop;
    logic [1:0][15:0] zmin;
    uim_counts_t [1:0] cnt;
    logic [5:0] hptr;
    logic [3:0] wptr;
    logic wr;
    logic wr2;
    uim_record_t rec;
    uim_record_t rec2;
    logic ev_v;
    uim_event_t ev;
    logic [47:0] ev_ts;
    logic [5:0][3:0] evq;
    uim_node_t node;
  } uim_state_bundle_t;
  uim_state_bundle_t s_q, s_d;
  logic [15:0] zhist [64];
  logic [15:0] z_pre20, z_pre200;
  logic [15:0] z [3];
  logic [15:0] zlow;
  logic [2:0] zloop;
  // ------------------------------------------------------------
  // Impedance per loop
  // ------------------------------------------------------------
  function automatic logic [15:0] imp(input logic [15:0] u, input logic [15:0] i);
    logic [31:0] q;
    q = 32'h0;
    if (i == 16'h0) begin
      q = 32'h0000ffff;
    end else begin
      q = ({16'h0, u} * {16'h0, `UIM_RATIO_SCALE}) / {16'h0, i};
    end
    imp = (q > 32'h0000ffff) ? 16'hffff : q[15:0];
  endfunction
  function automatic logic [15:0] rat(input logic [15:0] zz, input logic [15:0] thr);
    logic [31:0] q;
    q = 32'h0;
    if (thr == 16'h0) begin
      q = 32'h0;
    end else begin
      q = ({16'h0, zz} * {16'h0, `UIM_RATIO_SCALE}) / {16'h0, thr};
    end
    // The ratio port is 16 bits wide, so anything above its range saturates
    rat = (q > 32'h0000ffff) ? 16'hffff : q[15:0];
  endfunction
  always_comb begin
    z[0] = imp(meas.u1, meas.il1);
    z[1] = imp(meas.u2, meas.il2);
    z[2] = imp(meas.u3, meas.il3);
    case (op_mode)
      UIM_OPM_PP: begin
        z[0] = imp(meas.u1, meas.il1 + meas.il2);
        z[1] = imp(meas.u2, meas.il2 + meas.il3);
        z[2] = imp(meas.u3, meas.il3 + meas.il1);
      end
      UIM_OPM_PS: begin
        z[0] = imp(meas.u4, meas.il1);
        z[1] = 16'hffff;
        z[2] = 16'hffff;
      end
      default: begin
      end
    endcase
    zlow = z[0];
    zloop = 3'h1;
    if (z[1] < zlow) begin
      zlow = z[1];
      zloop = 3'h2;
    end
    if (z[2] < zlow) begin
      zlow = z[2];
      zloop = 3'h4;
    end
  end
  // ------------------------------------------------------------
  // Impedance history for pre-trigger values
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (cycle_tick) begin
      zhist[s_q.hptr] <= zlow;
    end
  end
  always_comb begin
    z_pre20 = zhist[(s_q.hptr >= `UIM_HIST_20MS) ? s_q.hptr - `UIM_HIST_20MS
                    : s_q.hptr + `UIM_HIST_LEN - `UIM_HIST_20MS];
    z_pre200 = zhist[(s_q.hptr >= `UIM_HIST_200MS) ? s_q.hptr - `UIM_HIST_200MS
                     : s_q.hptr + `UIM_HIST_LEN - `UIM_HIST_200MS];
  end
  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [23:0] rel;
    logic pk;
    logic en;
    logic [2:0] k;
    logic [1:0] kp;
    uim_record_t r;
    s_d = s_q;
    rel = 24'h0;
    pk = 1'b0;
    en = 1'b0;
    k = 3'h0;
    kp = 2'h0;
    r = '0;
    s_d.wr = 1'b0;
    s_d.ev_v = 1'b0;
    // One write port: a stage-two record waits one clock behind stage one
    if (s_q.wr2) begin
      s_d.wr = 1'b1;
      s_d.wr2 = 1'b0;
      s_d.rec = s_q.rec2;
    end
    if (node_mode_allowed) begin
      s_d.node = node_operating_mode;
    end else begin
      s_d.node = UIM_NODE_ON;
    end
    en = (s_q.node != UIM_NODE_OFF);
    if (s_q.evq != '0) begin
      s_d.evq = {4'h0, s_q.evq[5:1]};
      if (s_q.evq[0][1:0] != 2'h0) begin
        s_d.ev_v = 1'b1;
        s_d.ev = '{stage: s_q.evq[0][2] ? 2'h2 : 2'h1, kind: s_q.evq[0][1:0],
                   on: s_q.evq[0][3]};
        s_d.ev_ts = time_stamp;
      end
    end
    if (cycle_tick) begin
      s_d.hptr = (s_q.hptr == `UIM_HIST_LEN - 6'h1) ? 6'h0 : s_q.hptr + 6'h1;
      for (int n = 0; n < 2; n++) begin
        s_d.blk[n] = block_in[n] || (s_q.node == UIM_NODE_BLOCKED)
                     || (s_q.node == UIM_NODE_TEST_BLK);
        s_d.ratio[n] = rat(zlow, impedance_pickup_threshold[n]);
        rel = ({8'h0, impedance_pickup_threshold[n]} * {16'h0, `UIM_HYST_NUM})
              / {16'h0, `UIM_HYST_DEN};
        if (!s_q.pick[n]) begin
          pk = en && (zlow < impedance_pickup_threshold[n]);
        end else begin
          pk = en && ({8'h0, zlow} <= rel);
        end
        s_d.pick[n] = pk;
        case (s_q.st[n])
          UIM_ST_NORMAL: begin
            if (pk && s_d.blk[n]) begin
              s_d.st[n] = UIM_ST_BLOCKED;
            end else if (pk) begin
              s_d.st[n] = UIM_ST_START;
              s_d.tmr[n] = fixed_delay_characteristic[n];
            end
          end
          UIM_ST_START: begin
            if (!pk || s_d.blk[n]) begin
              s_d.st[n] = UIM_ST_NORMAL;
              s_d.tmr[n] = 20'h0;
            end else if (s_q.tmr[n] <= 20'h1) begin
              s_d.st[n] = UIM_ST_TRIP;
              s_d.tmr[n] = 20'h0;
            end else begin
              s_d.tmr[n] = s_q.tmr[n] - 20'h1;
            end
          end
          UIM_ST_TRIP: begin
            if (!pk || s_d.blk[n]) begin
              s_d.st[n] = UIM_ST_NORMAL;
            end
          end
          UIM_ST_BLOCKED: begin
            if (!pk || !s_d.blk[n]) begin
              s_d.st[n] = UIM_ST_NORMAL;
            end
          end
          default: begin
            s_d.st[n] = UIM_ST_NORMAL;
          end
        endcase
        if (s_d.st[n] != s_q.st[n]) begin
          k = 3'h0;
          case (s_d.st[n])
            UIM_ST_START: begin
              k = 3'h1;
              s_d.cnt[n].starts = s_q.cnt[n].starts + 16'h1;
            end
            UIM_ST_TRIP: begin
              k = 3'h2;
              s_d.cnt[n].trips = s_q.cnt[n].trips + 16'h1;
            end
            UIM_ST_BLOCKED: begin
              k = 3'h3;
              s_d.cnt[n].blocks = s_q.cnt[n].blocks + 16'h1;
            end
            default: k = 3'h0;
          endcase
          // Both stages may change in one cycle, so every event has its own slot
          if (k != 3'h0 && evt_on_sel[n]) begin
            s_d.evq[2 * n + 1] = {1'b1, n[0], k[1:0]};
          end
          if (k != 3'h0) begin
            r = '{stamp: time_stamp, evt: '{stage: n[0] ? 2'h2 : 2'h1,
                  kind: k[1:0], on: 1'b1}, loop: zloop, z_pre20: z_pre20,
                  z_now: zlow, z_pre200: z_pre200, t_remain: s_d.tmr[n],
                  group: setting_group};
            if (n == 0) begin
              s_d.wr = 1'b1;
              s_d.rec = r;
            end else begin
              s_d.wr2 = 1'b1;
              s_d.rec2 = r;
            end
          end
          if (evt_off_sel[n] && s_q.st[n] != UIM_ST_NORMAL) begin
            kp = (s_q.st[n] == UIM_ST_START) ? 2'h1
                 : (s_q.st[n] == UIM_ST_TRIP) ? 2'h2 : 2'h3;
            s_d.evq[2 * n] = {1'b0, n[0], kp};
          end
        end
      end
    end
    if (s_q.wr) begin
      s_d.wptr = (s_q.wptr == `UIM_LOG_LAST) ? 4'h0 : s_q.wptr + 4'h1;
    end
    if (counts_clear) begin
      s_d.cnt = '0;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= {UIM_ST_NORMAL, UIM_ST_NORMAL};
      s_q.node <= UIM_NODE_ON;
    end else begin
      s_q <= s_d;
    end
  end
  // ------------------------------------------------------------
  // Log memory and outputs
  // ------------------------------------------------------------
  uim_log_mem u_log (
    .clock(clock),
    .wr_en(s_q.wr),
    .wr_addr(s_q.wptr),
    .wr_data(s_q.rec),
    .rd_addr(log_rd_addr),
    .rd_data(log_rd_data)
  );
  for (genvar g = 0; g < 2; g++) begin : g_out
    always_comb begin
      condition[g] = (forcing_enabled) ? force_status[g] : s_q.st[g];
      start_out[g] = condition[g] == UIM_ST_START;
      trip_out[g] = condition[g] == UIM_ST_TRIP;
      blocked_out[g] = condition[g] == UIM_ST_BLOCKED;
      ratio_out[g] = s_q.ratio[g];
      expected_time[g] = fixed_delay_characteristic[g];
      remaining_time[g] = s_q.tmr[g];
      counts[g] = s_q.cnt[g];
    end
  end
  assign node_behaviour = s_q.node;
  assign event_valid = s_q.ev_v;
  assign event_data = s_q.ev;
  assign event_stamp = s_q.ev_ts;
  assign log_wr_ptr = s_q.wptr;
  AST_BLOCK_NO_START: assert property (@(posedge clock) disable iff (rst)
    cycle_tick && s_q.st[0] == UIM_ST_NORMAL && s_d.blk[0] |=> s_q.st[0] != UIM_ST_START)
    else $error("start entered while blocked");
  AST_DROP_ON_BLOCK: assert property (@(posedge clock) disable iff (rst)
    cycle_tick && s_q.st[0] == UIM_ST_START && block_in[0] |=> s_q.st[0] == UIM_ST_NORMAL)
    else $error("start kept under blocking");
  AST_TRIP_AFTER_START: assert property (@(posedge clock) disable iff (rst)
    $rose(s_q.st[0] == UIM_ST_TRIP) |-> $past(s_q.st[0]) == UIM_ST_START)
    else $error("trip without start");
  AST_REL_CLEARS: assert property (@(posedge clock) disable iff (rst)
    s_q.st[0] == UIM_ST_NORMAL |-> s_q.tmr[0] == 20'h0)
    else $error("timer not cleared");
  AST_LOG_WRAP: assert property (@(posedge clock) disable iff (rst)
    s_q.wptr <= `UIM_LOG_LAST) else $error("log pointer out of range");
  AST_COUNT_START: assert property (@(posedge clock) disable iff (rst)
    !$past(counts_clear) && $rose(s_q.st[0] == UIM_ST_START) |->
    s_q.cnt[0].starts == $past(s_q.cnt[0].starts) + 16'h1)
    else $error("start count missed");
  AST_NODE_OFF: assert property (@(posedge clock) disable iff (rst)
    s_q.node == UIM_NODE_OFF && cycle_tick |=> !s_q.pick[0])
    else $error("pickup while off");
  AST_FORCE: assert property (@(posedge clock) disable iff (rst)
    forcing_enabled |-> condition[1] == force_status[1])
    else $error("force not applied");
endmodule

// *** uim_front_model.sv ***
// Measurement front end and blocking matrix model feeding the protection block
`timescale 1ns/1ps
module uim_front_model
  import uim_pkg::*;
#(
  parameter int TICK_CLKS = 10
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Requests from the bench
  input wire logic [15:0] z_req,
  input wire logic [1:0] block_req,
  // Toward the block
  output logic cycle_tick,
  output uim_meas_t meas,
  output logic [47:0] time_stamp,
  output logic [1:0] block_in
);
  int div;
  // ----------------------------------------
  // Program cycle strobe and measurements
  // ----------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      div <= 0;
      cycle_tick <= 1'b0;
      meas <= '0;
      time_stamp <= 48'h0;
      block_in <= 2'h0;
    end else begin
      time_stamp <= time_stamp + 48'h1;
      div <= (div == TICK_CLKS - 1) ? 0 : div + 1;
      cycle_tick <= (div == TICK_CLKS - 1);
      // In phase-earth mode, unit currents make every loop impedance equal to the voltage figure
      if (div == 0) begin
        meas <= '{il1: 16'h0064, il2: 16'h0064, il3: 16'h0064,
                  u1: z_req, u2: z_req, u3: z_req, u4: z_req};
        // Blocking changes one full cycle ahead of any trip decision
        block_in <= block_req;
      end
    end
  end
endmodule

// *** tb_top.sv ***
// Self-checking testbench for the underimpedance protection block
`timescale 1ns/1ps
module tb_top;
  import uim_pkg::*;
  logic clock, rst, tick, node_mode_allowed, forcing_enabled, counts_clear;
  logic [15:0] z_req;
  logic [1:0] block_req, block_in, evt_on_sel, evt_off_sel;
  logic [1:0] start_out, trip_out, blocked_out;
  uim_meas_t meas;
  logic [47:0] time_stamp, event_stamp;
  uim_opmode_t op_mode;
  uim_node_t node_operating_mode, node_behaviour;
  uim_state_t force_status [2];
  uim_state_t condition [2];
  logic [15:0] thr [2];
  logic [19:0] dly [2];
  logic [2:0] setting_group;
  logic [15:0] ratio_out [2];
  logic [19:0] expected_time [2];
  logic [19:0] remaining_time [2];
  logic event_valid, seen_start, seen_trip;
  uim_event_t event_data;
  uim_counts_t counts [2];
  logic [3:0] log_rd_addr, log_wr_ptr;
  uim_record_t log_rd_data;
  int error_cnt, samples_checked;
  uim_front_model #(.TICK_CLKS(10)) i_front (.clock(clock), .rst(rst), .z_req(z_req),
    .block_req(block_req), .cycle_tick(tick), .meas(meas), .time_stamp(time_stamp),
    .block_in(block_in));
  uim_protection i_dut (.clock(clock), .rst(rst), .cycle_tick(tick), .meas(meas),
    .time_stamp(time_stamp), .op_mode(op_mode), .node_mode_allowed(node_mode_allowed),
    .node_operating_mode(node_operating_mode), .forcing_enabled(forcing_enabled),
    .force_status(force_status), .impedance_pickup_threshold(thr),
    .fixed_delay_characteristic(dly), .setting_group(setting_group),
    .evt_on_sel(evt_on_sel), .evt_off_sel(evt_off_sel), .block_in(block_in),
    .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
    .condition(condition), .node_behaviour(node_behaviour), .ratio_out(ratio_out),
    .expected_time(expected_time), .remaining_time(remaining_time),
    .event_valid(event_valid), .event_data(event_data), .event_stamp(event_stamp),
    .counts(counts), .counts_clear(counts_clear), .log_rd_addr(log_rd_addr),
    .log_rd_data(log_rd_data), .log_wr_ptr(log_wr_ptr));
  // ----------------------------------------
  // Clock and event watcher
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (event_valid === 1'b1 && event_data.on === 1'b1) begin
      if (event_data.kind === 2'h1) seen_start <= 1'b1;
      if (event_data.kind === 2'h2) seen_trip <= 1'b1;
    end
  end
  // ----------------------------------------
  // Bench tasks
  // ----------------------------------------
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_state(input uim_state_t got, input uim_state_t exp);
    chk_val({60'h0, got}, {60'h0, exp});
  endtask
  // Waits n program cycles, then lets the one-cycle answer settle
  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      while (tick !== 1'b1) @(posedge clock);
    end
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    error_cnt++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1; z_req = 16'h07d0; block_req = 2'h0; op_mode = UIM_OPM_PE;
    node_mode_allowed = 1'b1; node_operating_mode = UIM_NODE_ON; forcing_enabled = 1'b0;
    force_status = '{UIM_ST_NORMAL, UIM_ST_NORMAL}; thr = '{16'h03e8, 16'h03e8};
    dly = '{20'h00004, 20'h00064}; setting_group = 3'h2; evt_on_sel = 2'h3;
    evt_off_sel = 2'h3; counts_clear = 1'b0; log_rd_addr = 4'h0;
    seen_start = 1'b0; seen_trip = 1'b0; error_cnt = 0; samples_checked = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    ticks(1);
    chk_state(condition[0], UIM_ST_NORMAL);
    chk_val(node_behaviour, UIM_NODE_ON);
    chk_val(counts[0], 48'h0);
    // Pick-up below threshold, definite-time trip on stage one only
    @(posedge clock) z_req <= 16'h0384;
    ticks(2);
    chk_val(start_out, 2'h3);
    chk_val(trip_out, 2'h0);
    chk_state(condition[0], UIM_ST_START);
    chk_val(expected_time[0], 20'h00004);
    chk_val(ratio_out[0], 16'h005a);
    chk_val(remaining_time[0], 20'h00004);
    ticks(5);
    chk_val(trip_out, 2'h1);
    chk_state(condition[0], UIM_ST_TRIP);
    chk_val(counts[0].starts, 16'h0001);
    chk_val(counts[0].trips, 16'h0001);
    chk_val(counts[1].starts, 16'h0001);
    chk_val({seen_start, seen_trip}, 2'h3);
    @(posedge clock) log_rd_addr <= log_wr_ptr - 4'h1;
    repeat (2) @(posedge clock);
    #1;
    chk_val(log_rd_data.evt.on, 1'b1);
    chk_val(log_rd_data.evt.kind, 2'h2);
    chk_val(log_rd_data.z_now, 16'h0384);
    chk_val(log_rd_data.group, 3'h2);
    // Hysteresis: stays picked up below 103 percent, releases above
    @(posedge clock) z_req <= 16'h03fc;
    ticks(2);
    chk_val(start_out[1], 1'b1);
    @(posedge clock) z_req <= 16'h0410;
    ticks(2);
    chk_val({start_out, trip_out}, 4'h0);
    chk_state(condition[0], UIM_ST_NORMAL);
    chk_val(remaining_time[1], 20'h00000);
    // Blocked before pick-up on stage one, stage two independent
    @(posedge clock) begin
      block_req <= 2'h1;
      z_req <= 16'h0384;
    end
    ticks(3);
    chk_val({blocked_out, start_out}, 4'h6);
    chk_val(counts[0].blocks, 16'h0001);
    // Blocking arrives after stage two has started
    @(posedge clock) block_req <= 2'h2;
    ticks(3);
    chk_val(start_out[1], 1'b0);
    chk_val(trip_out[1], 1'b0);
    @(posedge clock) begin
      block_req <= 2'h0;
      z_req <= 16'h07d0;
    end
    ticks(3);
    // Threshold changed on the fly
    @(posedge clock) begin
      thr[0] <= 16'h0320;
      z_req <= 16'h03c0;
    end
    ticks(3);
    chk_val(start_out[0], 1'b0);
    chk_val(ratio_out[0], 16'h0078);
    @(posedge clock) thr[0] <= 16'h03e8;
    ticks(3);
    chk_val(start_out[0], 1'b1);
    @(posedge clock) z_req <= 16'h07d0;
    ticks(3);
    // Forced condition for every state
    for (int s = 0; s < 4; s++) begin
      @(posedge clock) begin
        forcing_enabled <= 1'b1;
        force_status[0] <= uim_state_t'(4'h1 << s);
      end
      ticks(2);
      chk_state(condition[0], uim_state_t'(4'h1 << s));
    end
    @(posedge clock) forcing_enabled <= 1'b0;
    // Node off ignores pick-up, and events are suppressed when deselected
    @(posedge clock) begin
      node_operating_mode <= UIM_NODE_OFF;
      z_req <= 16'h0384;
    end
    ticks(3);
    chk_val(start_out[0], 1'b0);
    chk_val(node_behaviour, UIM_NODE_OFF);
    @(posedge clock) begin
      node_operating_mode <= UIM_NODE_ON;
      z_req <= 16'h07d0;
      evt_on_sel <= 2'h0;
    end
    ticks(3);
    seen_start = 1'b0;
    // Every operating mode picks up a low impedance
    for (int m = 0; m < 3; m++) begin
      @(posedge clock) begin
        op_mode <= uim_opmode_t'(3'h1 << m);
        z_req <= 16'h0384;
      end
      ticks(2);
      chk_val(start_out[0], 1'b1);
      @(posedge clock) z_req <= 16'h07d0;
      ticks(3);
    end
    chk_val(seen_start, 1'b0);
    // Counter clear
    @(posedge clock) counts_clear <= 1'b1;
    @(posedge clock) counts_clear <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk_val(counts[0], 48'h0);
    tally_and_finish();
  end
endmodule
